//--- hw/ctm_pkg.sv
// constants, register map and encodings of the compact timer/pwm module
//
// Overview of operation
// - pause bit freezes the counter; clearing it resumes from the held value
// - clock select picks sys/4, sys, high/16, high/64, sub, pin rise or fall
// - rising edge of the on bit zeroes the counter, the only software change
// - on bit low stops counting; the counter keeps its residual value
// - in compare mode the on bit rising edge reloads the initial pin level
// - low three bits of control register zero always read as zero
// - mode field: 00 compare output, 10 pwm, 11 timer/counter, 01 undefined
// - in timer/counter mode the pin is unused; action, level, polarity ignored
// - compare mode match a: keep, drive low, drive high or toggle the pin
// - a match requesting the level already held gives no visible pin change
// - pwm mode action: 00 inactive, 01 active, 10 waveform, 11 undefined
// - output control bit: initial level in compare mode, active level in pwm
// - polarity bit set inverts the pin, clear passes it through
// - swap bit 0: compare p sets period, a duty; 1 swaps the roles
// - clear select: 1 match a clears, 0 match p or overflow; unused in pwm
// - counter readable, not writable, as low and high byte registers
// - compare a is a 16-bit read/write value in low and high bytes
// - compare p matches counter bits 15..8; period 256 times value, 65536 at 0
// - low bytes pass a shared buffer: loaded by low write or high read
// - the counter is a 16-bit up-counter stepped by the selected clock
// - outside pwm mode, with match a as clear source only the match a flag is raised
package tmr_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] REG_CTRL0  = 8'h00;
  localparam logic [7:0] REG_CTRL1  = 8'h04;
  localparam logic [7:0] REG_CNT_LO = 8'h08;
  localparam logic [7:0] REG_CNT_HI = 8'h0c;
  localparam logic [7:0] REG_CA_LO  = 8'h10;
  localparam logic [7:0] REG_CA_HI  = 8'h14;
  localparam logic [7:0] REG_CP     = 8'h18;
  localparam logic [7:0] REG_STAT   = 8'h1c;

  // field positions
  localparam int C0_PAUSE   = 7;
  localparam int C0_CKS_LSB = 4;
  localparam int C0_ON      = 3;
  localparam int C1_MODE    = 6;
  localparam int C1_ACT     = 4;
  localparam int C1_OC      = 3;
  localparam int C1_POL     = 2;
  localparam int C1_DPX     = 1;
  localparam int C1_CLR     = 0;
  localparam int ST_A       = 0;
  localparam int ST_P       = 1;

  localparam logic [7:0] CTRL0_MASK = 8'hf8;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [1:0] {
    MODE_CMP   = 2'b00,
    MODE_UNDEF = 2'b01,
    MODE_PWM   = 2'b10,
    MODE_TMR   = 2'b11
  } mode_e;

  typedef enum logic [2:0] {
    CKS_SYS4  = 3'b000,
    CKS_SYS   = 3'b001,
    CKS_H16   = 3'b010,
    CKS_H64   = 3'b011,
    CKS_SUB0  = 3'b100,
    CKS_SUB1  = 3'b101,
    CKS_PIN_R = 3'b110,
    CKS_PIN_F = 3'b111
  } cks_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WR   = 2'b01,
    BUS_RDW  = 2'b10,
    BUS_RD   = 2'b11
  } bus_e;

  // timing: high clock taken as the system clock, sub clock by division
  localparam int CLK_HZ      = 20_000_000;
  localparam int SUB_HZ      = 32_768;
  localparam int SUB_DIV     = CLK_HZ / SUB_HZ;
  localparam int SUB_W       = 10;
  localparam int PRE_W       = 6;

endpackage : tmr_pkg

//--- hw/compact_timer.sv
// compact 16-bit timer with compare/pwm output, ahb-lite register slave
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
module compact_timer (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [tmr_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [tmr_pkg::DATA_W-1:0] hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic      [tmr_pkg::DATA_W-1:0] hrdata,
  // pins
  input  wire logic                       external_clock_pin,
  output logic                            waveform_output_pin,
  output logic                            waveform_output_pin_oe,
  // match events
  output logic                            match_a_event,
  output logic                            match_p_event
);
  import tmr_pkg::*;

  bus_e             bus_q;
  logic [7:0]       addr_q;
  logic [7:0]       ctrl0_q;
  logic [7:0]       ctrl1_q;
  logic [15:0]      cnt_q;
  logic [15:0]      ca_q;
  logic [7:0]       cp_q;
  logic [7:0]       buf_q;
  logic [1:0]       flag_q;
  logic             start_q;
  logic             out_q;
  logic             pin_q;
  logic             oe_q;
  logic             a_evt_q;
  logic             p_evt_q;
  logic [PRE_W-1:0] pre_q;
  logic [SUB_W-1:0] sub_q;
  logic             ext_s1_q;
  logic             ext_s2_q;
  logic             ext_s3_q;

  logic             take;
  logic             wr;
  logic             tick;
  logic             run;
  logic [15:0]      cnt_inc;
  logic             a_hit;
  logic             p_hit;
  logic             clr_hit;
  logic             duty_on;
  logic [16:0]      duty_val;
  logic [7:0]       rd_byte;
  mode_e            mode;
  cks_e             cks;
  logic [1:0]       act;

  assign mode = mode_e'(ctrl1_q[C1_MODE +: 2]);
  assign cks  = cks_e'(ctrl0_q[C0_CKS_LSB +: 3]);
  assign act  = ctrl1_q[C1_ACT +: 2];

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
    is_reg = (a == r);
  endfunction : is_reg

  // ---------------- bus slave ----------------
  assign take      = hsel && htrans[1] && hready;
  assign wr        = (bus_q == BUS_WR);
  // reads take one wait state so that the data reflects any write just before
  assign hreadyout = (bus_q != BUS_RDW);
  assign hresp     = 1'b0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_q  <= BUS_IDLE;
      addr_q <= 8'h00;
    end else begin
      case (bus_q)
        BUS_RDW: bus_q <= BUS_RD;
        default: begin
          if (take) begin
            bus_q  <= hwrite ? BUS_WR : BUS_RDW;
            addr_q <= haddr[7:0];
          end else begin
            bus_q <= BUS_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    if (is_reg(addr_q, REG_CTRL0)) begin
      rd_byte = ctrl0_q & CTRL0_MASK;
    end else if (is_reg(addr_q, REG_CTRL1)) begin
      rd_byte = ctrl1_q;
    end else if (is_reg(addr_q, REG_CNT_LO) || is_reg(addr_q, REG_CA_LO)) begin
      rd_byte = buf_q;
    end else if (is_reg(addr_q, REG_CNT_HI)) begin
      rd_byte = cnt_q[15:8];
    end else if (is_reg(addr_q, REG_CA_HI)) begin
      rd_byte = ca_q[15:8];
    end else if (is_reg(addr_q, REG_CP)) begin
      rd_byte = cp_q;
    end else if (is_reg(addr_q, REG_STAT)) begin
      rd_byte = {6'h00, flag_q};
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_q == BUS_RDW) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl0_q <= RESET_BYTE;
      ctrl1_q <= RESET_BYTE;
      cp_q    <= RESET_BYTE;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (wr && is_reg(addr_q, REG_CTRL0)) begin
        ctrl0_q <= hwdata[7:0] & CTRL0_MASK;
        start_q <= hwdata[C0_ON] && !ctrl0_q[C0_ON];
      end
      if (wr && is_reg(addr_q, REG_CTRL1)) begin
        ctrl1_q <= hwdata[7:0];
      end
      if (wr && is_reg(addr_q, REG_CP)) begin
        cp_q <= hwdata[7:0];
      end
    end
  end

  // shared low-byte buffer and compare a
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_q <= RESET_BYTE;
      ca_q  <= 16'h0000;
    end else begin
      if (wr && is_reg(addr_q, REG_CA_LO)) begin
        buf_q <= hwdata[7:0];
      end else if (bus_q == BUS_RDW && is_reg(addr_q, REG_CNT_HI)) begin
        buf_q <= cnt_q[7:0];
      end else if (bus_q == BUS_RDW && is_reg(addr_q, REG_CA_HI)) begin
        buf_q <= ca_q[7:0];
      end
      if (wr && is_reg(addr_q, REG_CA_HI)) begin
        ca_q <= {hwdata[7:0], buf_q};
      end
    end
  end

  // ---------------- clock sources ----------------
  // free prescaler gives sys/4, high/16 and high/64 as enable pulses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= '0;
      sub_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
      if (sub_q == SUB_W'(SUB_DIV - 1)) begin
        sub_q <= '0;
      end else begin
        sub_q <= sub_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_clock_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  always_comb begin
    case (cks)
      CKS_SYS4:  tick = (pre_q[1:0] == 2'b11);
      CKS_SYS:   tick = 1'b1;
      CKS_H16:   tick = (pre_q[3:0] == 4'hf);
      CKS_H64:   tick = (pre_q == 6'h3f);
      CKS_PIN_R: tick = ext_s2_q && !ext_s3_q;
      CKS_PIN_F: tick = !ext_s2_q && ext_s3_q;
      default:   tick = (sub_q == SUB_W'(SUB_DIV - 1));
    endcase
  end

  // ---------------- counter and comparators ----------------
  assign run     = ctrl0_q[C0_ON] && !ctrl0_q[C0_PAUSE] && tick;
  assign cnt_inc = cnt_q + 16'h0001;
  // matches are seen on the step that would reach the compare value
  assign p_hit   = run && (cnt_inc == {cp_q, 8'h00});
  assign a_hit   = run && (cnt_inc == ca_q) && (ca_q != 16'h0000);

  always_comb begin
    if (mode == MODE_PWM) begin
      clr_hit = ctrl1_q[C1_DPX] ? a_hit : p_hit;
    end else begin
      clr_hit = ctrl1_q[C1_CLR] ? a_hit : p_hit;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
    end else if (start_q) begin
      cnt_q <= 16'h0000;
    end else if (clr_hit) begin
      cnt_q <= 16'h0000;
    end else if (run) begin
      cnt_q <= cnt_inc;
    end
  end

  // event pulses and sticky flags; a set wins over a write-one clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      a_evt_q <= 1'b0;
      p_evt_q <= 1'b0;
      flag_q  <= 2'b00;
    end else begin
      a_evt_q <= a_hit;
      p_evt_q <= p_hit && !(ctrl1_q[C1_CLR] && mode != MODE_PWM);
      if (wr && is_reg(addr_q, REG_STAT)) begin
        flag_q <= flag_q & ~hwdata[1:0];
      end
      if (a_evt_q) begin
        flag_q[ST_A] <= 1'b1;
      end
      if (p_evt_q) begin
        flag_q[ST_P] <= 1'b1;
      end
    end
  end

  assign match_a_event = a_evt_q;
  assign match_p_event = p_evt_q;

  // ---------------- output pin ----------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_q <= 1'b0;
    end else if (start_q) begin
      out_q <= ctrl1_q[C1_OC];
    end else if (a_hit && mode == MODE_CMP) begin
      case (act)
        2'b01:   out_q <= 1'b0;
        2'b10:   out_q <= 1'b1;
        2'b11:   out_q <= !out_q;
        default: out_q <= out_q;
      endcase
    end
  end

  // duty value of zero in swap mode stands for 65536 clocks
  always_comb begin
    if (ctrl1_q[C1_DPX]) begin
      duty_val = (cp_q == 8'h00) ? 17'h1_0000 : {1'b0, cp_q, 8'h00};
    end else begin
      duty_val = {1'b0, ca_q};
    end
    duty_on = ({1'b0, cnt_q} < duty_val);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      case (mode)
        MODE_CMP: begin
          pin_q <= out_q ^ ctrl1_q[C1_POL];
          oe_q  <= 1'b1;
        end
        MODE_PWM: begin
          // undefined action code 11 falls back to the inactive level
          pin_q <= ((act == 2'b01 || (act == 2'b10 && duty_on)) ~^ ctrl1_q[C1_OC])
                   ^ ctrl1_q[C1_POL];
          oe_q  <= 1'b1;
        end
        default: begin
          pin_q <= 1'b0;
          oe_q  <= 1'b0;
        end
      endcase
    end
  end

  assign waveform_output_pin    = pin_q;
  assign waveform_output_pin_oe = oe_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_read_req;
    take && !hwrite && bus_q != BUS_RDW;
  endsequence

  sequence s_read_ans;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait_state: assert property (s_read_req |=> s_read_ans)
    else $error("read answer not after one wait state");

  a_pause_holds: assert property (ctrl0_q[C0_PAUSE] && !start_q |=> $stable(cnt_q))
    else $error("counter moved while paused");

  a_off_holds: assert property (!ctrl0_q[C0_ON] && !start_q |=> $stable(cnt_q))
    else $error("counter moved while off");

  a_start_clears: assert property (start_q |=> cnt_q == 16'h0000)
    else $error("counter not zero after switch on");

  a_start_level: assert property (start_q |=> out_q == $past(ctrl1_q[C1_OC]))
    else $error("pin not at initial level after switch on");

  a_ctrl0_low_zero: assert property (
    bus_q == BUS_RD && is_reg(addr_q, REG_CTRL0) |-> hrdata[2:0] == 3'b000)
    else $error("unimplemented bits read nonzero");

  a_no_p_flag: assert property (
    ctrl1_q[C1_CLR] && mode != MODE_PWM && $stable(ctrl1_q) |=> !p_evt_q)
    else $error("match p event with match a clear source");

  a_p_clear: assert property (
    p_evt_q && mode == MODE_CMP && !ctrl1_q[C1_CLR] |-> cnt_q == 16'h0000)
    else $error("counter not cleared by match p");

  a_toggle_pin: assert property (
    a_evt_q && mode == MODE_CMP && act == 2'b11 && !$past(start_q)
    |-> out_q != $past(out_q))
    else $error("pin did not toggle on match a");

  a_timer_no_drive: assert property (mode == MODE_TMR |=> !waveform_output_pin_oe)
    else $error("pin driven in timer mode");

endmodule : compact_timer

//--- bench/ext_clk_src.sv
// partner model: drives bursts of pulses onto the external event clock pin
`timescale 1ns/1ps
module ext_clk_src (
  // clock
  input  wire logic       clk,
  // burst request
  input  wire logic       go,
  input  wire logic [7:0] n_edges,
  // pin and status
  output logic            pin,
  output logic            busy
);
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end

  // three clocks per phase so the 2-ff synchroniser never misses a level
  always begin
    @(posedge clk);
    if (go === 1'b1) begin
      busy <= 1'b1;
      repeat (n_edges) begin
        repeat (3) @(posedge clk);
        pin <= 1'b1;
        repeat (3) @(posedge clk);
        pin <= 1'b0;
      end
      busy <= 1'b0;
    end
  end
endmodule : ext_clk_src

//--- bench/compact_timer_test.sv
// self-checking bench for the compact timer: registers, pin and match events
`timescale 1ns/1ps
module compact_timer_test;
  import tmr_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        go = 1'b0;
  logic [7:0]  n_edges = 8'h00;
  logic        hready, hresp, ext_pin, pin, oe, ev_a, ev_p, busy;
  logic [31:0] hrdata;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          a_cnt = 0;
  int          p_cnt = 0;

  always #25 clk = ~clk;

  always @(posedge clk) begin
    if (ev_a === 1'b1) a_cnt++;
    if (ev_p === 1'b1) p_cnt++;
  end

  compact_timer dut_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .external_clock_pin(ext_pin),
    .waveform_output_pin(pin), .waveform_output_pin_oe(oe), .match_a_event(ev_a),
    .match_p_event(ev_p));

  ext_clk_src ext_u (.clk(clk), .go(go), .n_edges(n_edges), .pin(ext_pin), .busy(busy));

  task automatic wrap_up;
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic near(input logic [31:0] seen, input int lo, input int hi);
    check({31'h0, (seen >= lo && seen <= hi)}, 32'h1);
  endtask : near

  function automatic logic sig(input int w);
    case (w)
      0: return hready;
      1: return ev_a;
      default: return busy;
    endcase
  endfunction : sig

  // sampled at the falling edge, i.e. the level the next rising edge sees
  task automatic wait_for(input int w, input logic v);
    int k = 0;
    @(negedge clk);
    while (sig(w) !== v) begin
      k++;
      if (k > 2000) begin
        error_cnt++;
        wrap_up();
      end
      @(negedge clk);
    end
  endtask : wait_for

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    wait_for(0, 1'b1);
    @(posedge clk);
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    wait_for(0, 1'b1);
    q = hrdata[7:0];
    check({31'h0, hresp}, 32'h0);
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check({24'h0, q}, {24'h0, exp});
  endtask : rchk

  task automatic cnt(output logic [15:0] v);
    logic [7:0] h, l;
    bus(1'b0, REG_CNT_HI, 8'h00, h);
    bus(1'b0, REG_CNT_LO, 8'h00, l);
    v = {h, l};
  endtask : cnt

  task automatic setca(input logic [15:0] v);
    wr(REG_CA_LO, v[7:0]);
    wr(REG_CA_HI, v[15:8]);
  endtask : setca

  function automatic logic [7:0] c0(input logic p, input logic [2:0] k, input logic on);
    return {p, k, on, 3'b000};
  endfunction : c0

  function automatic logic [7:0] c1(input logic [1:0] m, input logic [1:0] act,
                                    input logic oc, input logic pol, input logic dpx,
                                    input logic clr);
    return {m, act, oc, pol, dpx, clr};
  endfunction : c1

  initial begin
    logic [15:0] v, w;
    logic [3:0]  aft;
    logic [1:0]  pa[6];
    logic        pp[6];
    logic        pd[6];
    int          pe[6];
    int          dv[6];
    int          e, k, j, hi;
    aft = 4'b1110;
    // last pwm entry uses the undefined action code, expected to stay inactive
    pa  = '{2'd0, 2'd1, 2'd2, 2'd2, 2'd2, 2'd3};
    pp  = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    pd  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    pe  = '{0, 1024, 256, 768, 512, 0};
    dv  = '{4, 1, 16, 64, SUB_DIV, SUB_DIV};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i <= 8; i++) rchk(8'(4 * i), 8'h00);
    wr(REG_CTRL0, 8'hf7);
    rchk(REG_CTRL0, 8'hf0);
    wr(REG_CTRL0, 8'h00);
    setca(16'h1234);
    rchk(REG_CA_HI, 8'h12);
    wr(REG_CA_LO, 8'h77);
    rchk(REG_CA_HI, 8'h12);
    rchk(REG_CA_LO, 8'h34);
    wr(REG_CNT_HI, 8'h55);
    rchk(REG_CNT_HI, 8'h00);
    wr(REG_CTRL1, c1(MODE_TMR, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0));
    setca(16'h0000);
    wr(REG_CP, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(REG_CTRL0, c0(1'b0, 3'(i), 1'b1));
      idle(1300);
      wr(REG_CTRL0, c0(1'b1, 3'(i), 1'b1));
      cnt(v);
      e = 1300 / dv[i];
      near({16'h0, v}, (e > 3) ? e - 3 : 1, e + 3);
      check({31'h0, oe}, 32'h0);
      idle(20);
      cnt(w);
      check({16'h0, w}, {16'h0, v});
      wr(REG_CTRL0, c0(1'b0, 3'(i), 1'b0));
      idle(20);
      cnt(w);
      check({16'h0, w}, {16'h0, v});
      wr(REG_CTRL0, c0(1'b1, 3'(i), 1'b1));
      cnt(w);
      check({16'h0, w}, 32'h0);
      wr(REG_CTRL0, 8'h00);
    end
    for (int i = 0; i < 2; i++) begin
      wr(REG_CTRL0, c0(1'b0, 3'(6 + i), 1'b1));
      n_edges <= 8'(5 + 2 * i);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wait_for(2, 1'b0);
      idle(6);
      wr(REG_CTRL0, c0(1'b1, 3'(6 + i), 1'b1));
      cnt(v);
      check({16'h0, v}, 32'(5 + 2 * i));
      wr(REG_CTRL0, 8'h00);
    end
    // compare p inside the compare a period with match a as clear source, so a match p must stay silent
    wr(REG_CP, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL0, 8'h00);
      wr(REG_CTRL1, c1(MODE_CMP, 2'(i), i[1], i[0], 1'b0, 1'b1));
      setca(16'h0140);
      wr(REG_CTRL0, c0(1'b0, 3'b001, 1'b1));
      idle(3);
      @(negedge clk);
      check({30'h0, oe, pin}, {30'h0, 1'b1, i[1] ^ i[0]});
      wait_for(1, 1'b1);
      @(negedge clk);
      check({31'h0, ev_a}, 32'h0);
      idle(2);
      @(negedge clk);
      check({31'h0, pin}, {31'h0, aft[i]});
      k = p_cnt;
      j = a_cnt;
      idle(700);
      check(p_cnt - k, 32'h0);
      near(a_cnt - j, 2, 3);
    end
    rchk(REG_STAT, 8'h01);
    wr(REG_CTRL0, 8'h00);
    wr(REG_CTRL1, c1(MODE_TMR, 2'b11, 1'b1, 1'b1, 1'b0, 1'b0));
    wr(REG_CP, 8'h01);
    setca(16'h0040);
    k = p_cnt;
    j = a_cnt;
    wr(REG_CTRL0, c0(1'b0, 3'b001, 1'b1));
    idle(1100);
    wr(REG_CTRL0, c0(1'b1, 3'b001, 1'b1));
    cnt(v);
    near({16'h0, v}, 0, 256);
    near(p_cnt - k, 4, 4);
    near(a_cnt - j, 4, 5);
    rchk(REG_STAT, 8'h03);
    wr(REG_STAT, 8'h03);
    rchk(REG_STAT, 8'h00);
    wr(REG_CTRL0, 8'h00);
    wr(REG_CP, 8'h00);
    setca(16'h0000);
    k = p_cnt;
    j = a_cnt;
    wr(REG_CTRL0, c0(1'b0, 3'b001, 1'b1));
    idle(66000);
    check(p_cnt - k, 32'h1);
    check(a_cnt - j, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(REG_CTRL0, 8'h00);
      wr(REG_CTRL1, c1(MODE_PWM, pa[i], 1'b1, pp[i], pd[i], 1'b1));
      setca(pd[i] ? 16'h0200 : 16'h0040);
      wr(REG_CP, 8'h01);
      wr(REG_CTRL0, c0(1'b0, 3'b001, 1'b1));
      idle(600);
      hi = 0;
      repeat (1024) begin
        @(negedge clk);
        if (pin === 1'b1) hi++;
      end
      near(hi, (pe[i] > 8) ? pe[i] - 8 : 0, pe[i] + 8);
      check({31'h0, oe}, 32'h1);
      idle(1);
    end
    wr(REG_CTRL0, 8'h00);
    wr(REG_CTRL1, c1(MODE_UNDEF, 2'b10, 1'b1, 1'b0, 1'b0, 1'b0));
    idle(2);
    @(negedge clk);
    check({31'h0, oe}, 32'h0);
    wrap_up();
  end

  // the whole sequence needs about 90k cycles, mostly the full-overflow wait
  initial begin
    repeat (97000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule : compact_timer_test
